// >>> pmt_top.sv
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module pmt_top (
  input  wire logic                        clock_in,
  input  wire logic                        rstn_in,
  input  wire logic [pmt_pkg::ADDR_W-1:0]  addr_in,
  input  wire logic [pmt_pkg::DATA_W-1:0]  wdata_in,
  input  wire logic                        wr_in,
  input  wire logic                        rd_in,
  output logic      [pmt_pkg::DATA_W-1:0]  rdata_out,
  output logic                             irq_out
);

  // Register state
  logic [pmt_pkg::DATA_W-1:0] count_r;
  logic [pmt_pkg::DATA_W-1:0] period_r;
  logic [pmt_pkg::CTL_W-1:0]  ctrl_r;
  logic                       status_r;
  logic                       enable_r;
  logic                       irq_r;
  logic [pmt_pkg::DATA_W-1:0] rdata_r;
  logic                       eq_prev_r;
  logic                       tick_prev_r;

  // Next values
  logic [pmt_pkg::DATA_W-1:0] count_nxt;
  logic                       status_nxt;
  logic [pmt_pkg::DATA_W-1:0] rdata_nxt;

  // Decoded strobes
  logic                       wr_ctrl;
  logic                       wr_period;
  logic                       wr_count;
  logic                       wr_clear;
  logic                       wr_enable;

  // Comparator and event
  logic                       eq;
  logic                       match_evt;
  logic                       timer_on;

  pmt_pre_if pre_if ();

  function automatic logic hit(input logic strobe,
                               input logic [pmt_pkg::ADDR_W-1:0] addr,
                               input logic [pmt_pkg::ADDR_W-1:0] offset);
    hit = strobe && (addr == offset);
  endfunction

  assign wr_ctrl   = hit(wr_in, addr_in, pmt_pkg::OFF_CONTROL);
  assign wr_period = hit(wr_in, addr_in, pmt_pkg::OFF_PERIOD);
  assign wr_count  = hit(wr_in, addr_in, pmt_pkg::OFF_COUNT);
  assign wr_clear  = hit(wr_in, addr_in, pmt_pkg::OFF_CLEAR);
  assign wr_enable = hit(wr_in, addr_in, pmt_pkg::OFF_ENABLE);

  assign timer_on = ctrl_r[pmt_pkg::CTL_ON_BIT];

  assign pre_if.clr = wr_ctrl | wr_count;
  assign pre_if.run = timer_on;
  assign pre_if.sel = pmt_pkg::pmt_ps_t'(ctrl_r[pmt_pkg::CTL_PS_MSB:pmt_pkg::CTL_PS_LSB]);

  pmt_prescaler u_pre (
    .clock_in (clock_in),
    .rstn_in  (rstn_in),
    .pre      (pre_if.pre)
  );

  assign eq = (count_r == period_r);

  // Fires once per arrival at the period, and again on every reload
  // when the period is zero, so a steady match does not refire
  assign match_evt = eq && (!eq_prev_r || tick_prev_r);

  always_comb begin
    count_nxt = count_r;
    if (wr_count) begin
      count_nxt = wdata_in;
    end else if (pre_if.tick) begin
      if (eq) begin
        count_nxt = pmt_pkg::COUNT_RST;
      end else begin
        count_nxt = count_r + 8'h01;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count_r <= pmt_pkg::COUNT_RST;
    end else begin
      count_r <= count_nxt;
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      period_r <= pmt_pkg::PERIOD_RST;
    end else if (wr_period) begin
      period_r <= wdata_in;
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_r <= pmt_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= wdata_in[pmt_pkg::CTL_W-1:0];
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      eq_prev_r   <= 1'b0;
      tick_prev_r <= 1'b0;
    end else begin
      eq_prev_r   <= eq;
      tick_prev_r <= pre_if.tick;
    end
  end

  always_comb begin
    status_nxt = status_r;
    if (wr_clear && wdata_in[pmt_pkg::MATCH_BIT]) begin
      status_nxt = 1'b0;
    end
    if (match_evt) begin
      status_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      status_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      enable_r <= 1'b0;
    end else if (wr_enable) begin
      enable_r <= wdata_in[pmt_pkg::MATCH_BIT];
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= status_r && enable_r;
    end
  end

  always_comb begin
    rdata_nxt = '0;
    case (addr_in)
      pmt_pkg::OFF_CONTROL: begin
        rdata_nxt[pmt_pkg::CTL_W-1:0] = ctrl_r;
      end
      pmt_pkg::OFF_PERIOD: begin
        rdata_nxt = period_r;
      end
      pmt_pkg::OFF_COUNT: begin
        rdata_nxt = count_r;
      end
      pmt_pkg::OFF_STATUS: begin
        rdata_nxt[pmt_pkg::MATCH_BIT] = status_r;
      end
      pmt_pkg::OFF_ENABLE: begin
        rdata_nxt[pmt_pkg::MATCH_BIT] = enable_r;
      end
      default: begin
        rdata_nxt = '0;
      end
    endcase
  end

  // Data stand one cycle only, so stale values never look like answers
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_r <= '0;
    end else if (rd_in) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= '0;
    end
  end

  assign rdata_out = rdata_r;
  assign irq_out   = irq_r;

  default clocking cb @(posedge clock_in);
  endclocking

  default disable iff (!rstn_in);

  logic                       steady4;
  logic                       steady8;
  logic                       steady16;
  logic [pmt_pkg::PS_W-1:0]   gap16_r;

  assign steady4 = timer_on && (pre_if.sel == pmt_pkg::PMT_DIV4) && !pre_if.clr;
  assign steady8 = timer_on && (pre_if.sel == pmt_pkg::PMT_DIV8) && !pre_if.clr;
  assign steady16 = timer_on && (pre_if.sel == pmt_pkg::PMT_DIV16) && !pre_if.clr;

  // Sixteen cycles exceed what a repetition may unroll, so count the gap
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      gap16_r <= '0;
    end else if (!steady16 || pre_if.tick) begin
      gap16_r <= '0;
    end else begin
      gap16_r <= gap16_r + 4'h1;
    end
  end

  chk_reset_values: assert property (
    !$past(rstn_in) |-> (count_r == pmt_pkg::COUNT_RST) && (period_r == pmt_pkg::PERIOD_RST)
      && (ctrl_r == pmt_pkg::CTRL_RST))
    else $error("reset values wrong");

  chk_count_step: assert property (
    (pre_if.tick && !eq && !wr_count) |=> count_r == $past(count_r) + 8'h01)
    else $error("count did not advance on prescaler pulse");

  chk_count_wrap: assert property (
    (pre_if.tick && eq && !wr_count) |=> count_r == pmt_pkg::COUNT_RST)
    else $error("count did not wrap after match");

  chk_divide_four: assert property (
    (pre_if.tick && steady4) ##1 steady4 [*4] |-> pre_if.tick)
    else $error("divide by four spacing wrong");

  chk_divide_eight: assert property (
    (pre_if.tick && steady8) ##1 steady8 [*8] |-> pre_if.tick)
    else $error("divide by eight spacing wrong");

  chk_match_flag: assert property (
    (eq && !eq_prev_r) |=> status_r)
    else $error("match did not set flag");

  chk_halt_off: assert property (
    (!timer_on && !wr_count) |=> $stable(count_r))
    else $error("count moved while timer off");

  chk_write_regs: assert property (
    (wr_count || wr_period) |=> (!$past(wr_count) || (count_r == $past(wdata_in)))
      && (!$past(wr_period) || (period_r == $past(wdata_in))))
    else $error("software write lost");

  chk_ctrl_keep: assert property (
    wr_ctrl |=> $stable(count_r))
    else $error("control write changed count");

  chk_ctrl_read: assert property (
    (rd_in && addr_in == pmt_pkg::OFF_CONTROL) |=> rdata_out[pmt_pkg::DATA_W-1:pmt_pkg::CTL_W] == '0)
    else $error("upper control bits not zero");

  chk_flag_sticky: assert property (
    (status_r && !wr_clear) ##1 !wr_clear |-> status_r ##1 status_r)
    else $error("flag dropped without clear");

  chk_irq_gate: assert property (
    irq_out |-> $past(status_r && enable_r))
    else $error("interrupt without enabled flag");

  chk_irq_follow: assert property (
    (status_r && enable_r) |=> irq_out)
    else $error("enabled flag gave no interrupt");

  chk_clear_flag: assert property (
    (wr_clear && wdata_in[pmt_pkg::MATCH_BIT] && !match_evt) |=> !status_r)
    else $error("flag not cleared by write");

  chk_divide_one: assert property (
    (timer_on && (pre_if.sel == pmt_pkg::PMT_DIV1) && !pre_if.clr) |-> pre_if.tick)
    else $error("divide by one missed a pulse");

  chk_divide_sixteen: assert property (
    steady16 |-> pre_if.tick == (gap16_r == pmt_pkg::pmt_last(pmt_pkg::PMT_DIV16)))
    else $error("divide by sixteen spacing wrong");

  chk_read_idle: assert property (
    !rd_in |=> rdata_out == '0)
    else $error("read data outside read cycle");

  cov_wrap: cover property (pre_if.tick && eq ##1 count_r == pmt_pkg::COUNT_RST);
  cov_irq: cover property ($rose(irq_out));
  cov_div16: cover property (pre_if.tick && pre_if.sel == pmt_pkg::PMT_DIV16);
  cov_set_clear: cover property (match_evt && wr_clear);
  cov_count_write: cover property (wr_count && timer_on);

endmodule

// >>> pmt_pkg.sv
// Contract
// - Count and period are eight bits wide
// - Oscillator feeds prescaler; each pulse increments count
// - Prescale codes select divide 1, 4, 8, 16
// - Count up; after match next increment loads zero
// - Equality of count and period sets match flag
// - Software reads and writes count and period anytime
// - Reset: count zero, period all ones
// - Timer runs only while on bit is set
// - Count or control write clears prescale counter
// - Control write leaves count unchanged
// - Upper control bits read zero, reset zero
package pmt_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int CTL_W  = 3;
  localparam int PS_W   = 4;

  localparam logic [ADDR_W-1:0] OFF_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_PERIOD  = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_COUNT   = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_STATUS  = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_CLEAR   = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_ENABLE  = 4'h5;

  localparam int CTL_ON_BIT = 2;
  localparam int CTL_PS_LSB = 0;
  localparam int CTL_PS_MSB = 1;
  localparam int MATCH_BIT  = 0;

  localparam logic [DATA_W-1:0] COUNT_RST  = 8'h00;
  localparam logic [DATA_W-1:0] PERIOD_RST = 8'hFF;
  localparam logic [CTL_W-1:0]  CTRL_RST   = 3'h0;
  localparam logic [PS_W-1:0]   PS_RST     = 4'h0;

  typedef enum logic [1:0] {
    PMT_DIV1,
    PMT_DIV4,
    PMT_DIV8,
    PMT_DIV16
  } pmt_ps_t;

  // Divide code decode
  // Terminal value of the prescale counter for each setting
  function automatic logic [PS_W-1:0] pmt_last(input pmt_ps_t sel);
    case (sel)
      PMT_DIV1: pmt_last = 4'h0;
      PMT_DIV4: pmt_last = 4'h3;
      PMT_DIV8: pmt_last = 4'h7;
      default:  pmt_last = 4'hF;
    endcase
  endfunction

endpackage

// >>> pmt_pre_if.sv
`timescale 1ns/1ps
interface pmt_pre_if;
  logic                clr;
  logic                run;
  pmt_pkg::pmt_ps_t    sel;
  logic                tick;

  modport ctl (output clr, output run, output sel, input tick);
  modport pre (input clr, input run, input sel, output tick);
endinterface

// >>> pmt_prescaler.sv
`timescale 1ns/1ps
module pmt_prescaler (
  input  wire logic  clock_in,
  input  wire logic  rstn_in,
  pmt_pre_if.pre     pre
);

  logic [pmt_pkg::PS_W-1:0] cnt_r;
  logic [pmt_pkg::PS_W-1:0] last;
  logic                     at_last;

  assign last    = pmt_pkg::pmt_last(pre.sel);
  // Compare with >= so a smaller divide picked mid-count still wraps
  assign at_last = (cnt_r >= last);

  assign pre.tick = pre.run && !pre.clr && at_last;

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_r <= pmt_pkg::PS_RST;
    end else if (pre.clr) begin
      cnt_r <= pmt_pkg::PS_RST;
    end else if (pre.run) begin
      if (at_last) begin
        cnt_r <= pmt_pkg::PS_RST;
      end else begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end

  chk_pre_clear_zero: assert property (@(posedge clock_in) disable iff (!rstn_in)
    pre.clr |=> cnt_r == pmt_pkg::PS_RST)
    else $error("prescale counter not cleared");

endmodule

// >>> pmt_top_test.sv
`timescale 1ns/1ps
module pmt_top_test;
  logic                       clock_in;
  logic                       rstn_in;
  logic [pmt_pkg::ADDR_W-1:0] addr_in;
  logic [pmt_pkg::DATA_W-1:0] wdata_in;
  logic                       wr_in;
  logic                       rd_in;
  logic [pmt_pkg::DATA_W-1:0] rdata_out;
  logic                       irq_out;
  logic                       rd_pend;
  logic [7:0]                 exp_q[$];
  int                         miscompares;
  int                         check_count;
  int                         cyc;
  int                         base;
  int                         c0;
  int                         n;
  int                         per;
  int                         ps;
  bit                         run;

  pmt_top u_dut (
    .clock_in  (clock_in),
    .rstn_in   (rstn_in),
    .addr_in   (addr_in),
    .wdata_in  (wdata_in),
    .wr_in     (wr_in),
    .rd_in     (rd_in),
    .rdata_out (rdata_out),
    .irq_out   (irq_out)
  );

  initial clock_in = 1'b0;
  always #20 clock_in = ~clock_in;
  always @(posedge clock_in) cyc <= cyc + 1;

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] expv);
    check_count++;
    if (seen !== expv) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", name, expv, seen);
    end
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge clock_in) begin
    if (rd_pend) begin
      if (exp_q.size() == 0) check("read queue", 8'h00, 8'hFF);
      else check("read data", rdata_out, exp_q.pop_front());
    end
    rd_pend <= rd_in;
  end

  // Count model: pulses fall on edges c0 + n*k, k >= 1; wrap after period
  function automatic int cur(input int t);
    if (!run) return base;
    return (base + (t - c0 - 1) / n) % (per + 1);
  endfunction

  task automatic idle(input int k);
    repeat (k) @(posedge clock_in);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clock_in);
    wr_in <= 1'b0;
    @(posedge clock_in);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] expv);
    exp_q.push_back(expv);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    @(posedge clock_in);
  endtask

  // A control write restarts the prescaler but keeps the count
  task automatic wr_ctl(input bit on, input logic [1:0] sel);
    int t;
    t = cyc + 1;
    base = cur(t);
    c0 = t;
    run = on;
    n = (sel == 2'd0) ? 1 : (sel == 2'd1) ? 4 : (sel == 2'd2) ? 8 : 16;
    wr(pmt_pkg::OFF_CONTROL, {5'h00, on, sel});
  endtask

  task automatic wr_cnt(input logic [7:0] v);
    base = v;
    c0 = cyc + 1;
    wr(pmt_pkg::OFF_COUNT, v);
  endtask

  task automatic rd_cnt;
    rd(pmt_pkg::OFF_COUNT, 8'(cur(cyc + 1)));
  endtask

  task automatic results;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock_in);
    miscompares++;
    results();
  end

  initial begin
    rstn_in = 1'b0;
    addr_in = 4'h0;
    wdata_in = 8'h00;
    wr_in = 1'b0;
    rd_in = 1'b0;
    rd_pend = 1'b0;
    cyc = 0;
    base = 0;
    c0 = 0;
    n = 1;
    per = 255;
    run = 1'b0;
    ps = $urandom(32'h66ED);
    repeat (12) @(posedge clock_in);
    rstn_in <= 1'b1;
    @(posedge clock_in);
    rd(pmt_pkg::OFF_CONTROL, 8'h00);
    rd(pmt_pkg::OFF_PERIOD, 8'hFF);
    rd(pmt_pkg::OFF_COUNT, 8'h00);
    rd(pmt_pkg::OFF_STATUS, 8'h00);
    rd(pmt_pkg::OFF_CLEAR, 8'h00);
    rd(4'hF, 8'h00);
    wr(pmt_pkg::OFF_CONTROL, 8'hF8);
    wr(pmt_pkg::OFF_STATUS, 8'hFF);
    rd(pmt_pkg::OFF_CONTROL, 8'h00);
    rd(pmt_pkg::OFF_STATUS, 8'h00);
    per = $urandom_range(3, 7);
    wr(pmt_pkg::OFF_PERIOD, 8'(per));
    rd(pmt_pkg::OFF_PERIOD, 8'(per));
    // Every prescale code, with wraps at a small period
    for (ps = 0; ps < 4; ps++) begin
      wr_cnt(8'h00);
      wr_ctl(1'b1, ps[1:0]);
      repeat (4) begin
        idle($urandom_range(0, 20));
        rd_cnt();
      end
      wr_ctl(1'b0, ps[1:0]);
      idle(5);
      rd_cnt();
    end
    // Flag set while masked; irq stays low
    rd(pmt_pkg::OFF_STATUS, 8'h01);
    check("irq masked", {7'h00, irq_out}, 8'h00);
    wr(pmt_pkg::OFF_ENABLE, 8'h01);
    idle(2);
    check("irq enabled", {7'h00, irq_out}, 8'h01);
    wr(pmt_pkg::OFF_CLEAR, 8'h01);
    idle(2);
    check("irq cleared", {7'h00, irq_out}, 8'h00);
    rd(pmt_pkg::OFF_STATUS, 8'h00);
    // Count write mid-run restarts the prescale phase
    wr_ctl(1'b1, 2'd1);
    idle($urandom_range(1, 6));
    wr_cnt(8'($urandom_range(0, per)));
    rd_cnt();
    idle(9);
    rd_cnt();
    wr_ctl(1'b0, 2'd1);
    wr(pmt_pkg::OFF_CLEAR, 8'h01);
    // Arrival at the period raises the interrupt
    wr_cnt(8'h00);
    wr_ctl(1'b1, 2'd0);
    idle(per + 3);
    check("irq match", {7'h00, irq_out}, 8'h01);
    wr_ctl(1'b0, 2'd0);
    rd_cnt();
    idle(3);
    if (exp_q.size() != 0) miscompares++;
    results();
  end
endmodule
